// ### verilog/ces_pkg.sv
// ============================================================
// Completion stream sideband constants
// ============================================================
package ces_pkg;

    // Stream widths
    localparam int DATA_W   = 512;               // Completion data bus width
    localparam int BYTE_N   = 64;                // Bytes per beat, one parity bit each
    localparam int SB_W     = 161;               // Completion sideband width
    localparam int SLOT_N   = 4;                 // Straddled TLPs per beat
    localparam int CNT_W    = 3;                 // Width of a 0..4 count
    localparam int DWP_W    = 4;                 // Width of one last-Dword offset
    localparam int LANE_W   = 2;                 // Width of one start lane code

    // Sideband field positions
    localparam int SB_START_LSB = 64;            // Start flags 67:64
    localparam int SB_SPTR_LSB  = 68;            // Start lane codes 75:68
    localparam int SB_END_LSB   = 76;            // End flags 79:76
    localparam int SB_EPTR_LSB  = 80;            // Last-Dword offsets 95:80
    localparam int SB_DISC_BIT  = 96;            // Discard flag
    localparam int SB_PAR_LSB   = 97;            // Odd parity 160:97

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;   // Control
    localparam logic [7:0] REG_STATUS = 8'h04;   // Sticky events, write one to clear
    localparam logic [7:0] REG_MASK   = 8'h08;   // Interrupt mask
    localparam logic [7:0] REG_BEATS  = 8'h0c;   // Delivered beat count
    localparam int         ADDR_W     = 8;       // Decoded address bits

    // Control bits
    localparam int CTRL_STRADDLE = 0;            // Straddling enable
    localparam int CTRL_ENDPOINT = 1;            // Endpoint configuration
    localparam int CTRL_W        = 2;            // Implemented control bits

    // Status and mask bits
    localparam int EV_DISCARD    = 0;            // A TLP was discarded
    localparam int EV_START_HELD = 1;            // Starts suppressed after discard
    localparam int EV_W          = 2;            // Implemented event bits

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;  // Straddle off, not endpoint
    localparam logic [EV_W-1:0]   EV_RST   = 2'h0;  // No events, all masked
    localparam int                BEAT_W   = 32;    // Beat counter width

endpackage

// ### verilog/ces_parity.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Per-byte odd parity of one data beat
// ============================================================
module ces_parity
    import ces_pkg::*;
(
    // Data in
    input  wire logic [DATA_W-1:0] data,
    // Parity out, one bit per byte
    output logic      [BYTE_N-1:0] parity
);

    // One odd-parity bit per byte lane
    genvar i;
    generate
        for (i = 0; i < BYTE_N; i++) begin : g_byte
            assign parity[i] = ~(^data[8*i +: 8]);
        end
    endgenerate

endmodule
`default_nettype wire

// ### verilog/ces_framer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - End flags thermometer coded, zero to four
// - End flags at 79:76, straddle only
// - Non-straddle: last marks each TLP final beat
// - First last-Dword offset at 83:80, flag bit0
// - Other offsets at 87:84, 91:88, 95:92
// - Offsets held zero without straddling
// - Discard flag bit 96 on payload error
// - Discard only with payload, final beat
// - Endpoint reports payload error upstream
// - Per-byte odd parity at 160:97
// - Start flags 67:64, bit0 only unstraddled
// - Start lane codes, first at 69:68
// ============================================================
// Completion stream framer with APB control
// ============================================================
module ces_framer
    import ces_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [ADDR_W-1:0]      paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Interrupt
    output logic                        irq,
    // Beat source from the core's completion buffer
    input  wire logic                   src_valid,
    output logic                        src_ready,
    input  wire logic [DATA_W-1:0]      src_data,
    input  wire logic [CNT_W-1:0]       src_start_count,
    input  wire logic [SLOT_N*LANE_W-1:0] src_start_lanes,
    input  wire logic [CNT_W-1:0]       src_end_count,
    input  wire logic [SLOT_N*DWP_W-1:0] src_end_offsets,
    input  wire logic                   src_last,
    input  wire logic                   src_payload_error,
    input  wire logic                   src_has_payload,
    // Completion stream to client logic
    output logic                        completion_stream_valid,
    input  wire logic                   completion_stream_ready,
    output logic [DATA_W-1:0]           completion_stream_data,
    output logic                        completion_stream_last,
    output logic [SB_W-1:0]             completion_sideband,
    // Error report request toward the error reporting logic
    output logic                        aer_report
);

    // ========================================================
    // Helper functions
    // ========================================================

    // Count of slots to thermometer flags; over-range saturates at four
    function automatic logic [SLOT_N-1:0] thermo(input logic [CNT_W-1:0] n);
        logic [SLOT_N-1:0] t;
        t = '0;
        for (int k = 0; k < SLOT_N; k++) begin
            if (n > k[CNT_W-1:0]) begin
                t[k] = 1'b1;
            end
        end
        return t;
    endfunction

    // Address is one of the mapped registers
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_MASK) || (a == REG_BEATS);
    endfunction

    // ========================================================
    // Registers and wires
    // ========================================================
    logic [CTRL_W-1:0]  ctrl;           // Straddle and endpoint control
    logic [CTRL_W-1:0]  next_ctrl;
    logic [EV_W-1:0]    status;         // Sticky events
    logic [EV_W-1:0]    next_status;
    logic [EV_W-1:0]    mask;           // Interrupt enables
    logic [EV_W-1:0]    next_mask;
    logic [BEAT_W-1:0]  beats;          // Handshaked beat counter
    logic [BEAT_W-1:0]  next_beats;
    logic [31:0]        next_prdata;
    logic               wr_en;          // APB write in access phase
    logic               rd_setup;       // APB read in setup phase
    logic [EV_W-1:0]    ev_set;         // Events raised this cycle

    logic               straddle;       // Straddling enabled
    logic               load;           // Output stage takes a new beat
    logic               xfer;           // Output handshake completes
    logic [BYTE_N-1:0]  par;            // Parity of incoming beat

    logic               next_valid;
    logic [DATA_W-1:0]  next_data;
    logic               next_last;
    logic [SB_W-1:0]    next_sb;
    logic               next_aer;
    logic               disc;           // Discard applies to this beat
    logic               held;           // Starts suppressed this beat
    logic [SLOT_N-1:0]  end_f;
    logic [SLOT_N-1:0]  start_f;

    assign straddle = ctrl[CTRL_STRADDLE];

    // ========================================================
    // Parity generator
    // ========================================================
    ces_parity u_parity (
        .data   (src_data),
        .parity (par)
    );

    // ========================================================
    // Stream handshake
    // ========================================================

    // Single output stage; it refills when empty or drained
    assign xfer      = completion_stream_valid & completion_stream_ready;
    assign src_ready = ~completion_stream_valid | completion_stream_ready;
    assign load      = src_ready;

    // ========================================================
    // Beat framing
    // ========================================================

    // Builds the next output beat and its sideband
    always_comb begin
        end_f      = thermo(src_end_count);
        start_f    = thermo(src_start_count);
        next_valid = completion_stream_valid;
        next_data  = completion_stream_data;
        next_last  = completion_stream_last;
        next_sb    = completion_sideband;
        disc       = 1'b0;
        held       = 1'b0;
        if (load) begin
            next_valid = src_valid;
            next_data  = src_data;
            next_sb    = '0;
            // Discard needs payload and the TLP's final beat
            if (straddle) begin
                disc = src_payload_error & src_has_payload & end_f[0];
            end else begin
                disc = src_payload_error & src_has_payload & src_last;
            end
            next_sb[SB_DISC_BIT] = disc;
            if (straddle) begin
                // Thermometer end flags, final beats only
                next_sb[SB_END_LSB +: SLOT_N] = end_f;
                // Each offset only where its flag is set
                for (int k = 0; k < SLOT_N; k++) begin
                    if (end_f[k]) begin
                        next_sb[SB_EPTR_LSB + k*DWP_W +: DWP_W] =
                            src_end_offsets[k*DWP_W +: DWP_W];
                    end
                end
                // No TLP may begin in a beat that carries a discard
                if (disc && start_f != '0) begin
                    held = 1'b1;
                end else begin
                    next_sb[SB_START_LSB +: SLOT_N] = start_f;
                    for (int k = 0; k < SLOT_N; k++) begin
                        if (start_f[k]) begin
                            next_sb[SB_SPTR_LSB + k*LANE_W +: LANE_W] =
                                src_start_lanes[k*LANE_W +: LANE_W];
                        end
                    end
                end
                // Last-beat marker unused when straddling
                next_last = 1'b0;
            end else begin
                // Unstraddled: last marks the end, offsets stay zero
                next_last = src_last;
                next_sb[SB_START_LSB] = start_f[0];
            end
            next_sb[SB_PAR_LSB +: BYTE_N] = par;
        end
    end

    // Endpoint mode forwards payload errors to error reporting
    always_comb begin
        next_aer = xfer & completion_sideband[SB_DISC_BIT] & ctrl[CTRL_ENDPOINT];
    end

    // Output stage registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            completion_stream_valid <= 1'b0;
            completion_stream_data  <= '0;
            completion_stream_last  <= 1'b0;
            completion_sideband     <= '0;
            aer_report              <= 1'b0;
        end else begin
            completion_stream_valid <= next_valid;
            completion_stream_data  <= next_data;
            completion_stream_last  <= next_last;
            completion_sideband     <= next_sb;
            aer_report              <= next_aer;
        end
    end

    // ========================================================
    // APB register file
    // ========================================================

    // Zero-wait slave; errors only on unmapped access
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);
    assign wr_en   = psel & penable & pwrite & mapped(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;

    // Discard event on completed beats, start-held event when the beat is loaded
    always_comb begin
        ev_set                = '0;
        ev_set[EV_DISCARD]    = xfer & completion_sideband[SB_DISC_BIT];
        ev_set[EV_START_HELD] = load & src_valid & held;
    end

    // Next register values; a new event beats its own clear
    always_comb begin
        next_ctrl   = ctrl;
        next_mask   = mask;
        next_status = status;
        next_beats  = beats;
        next_prdata = prdata;
        if (wr_en) begin
            case (paddr)
                REG_CTRL: begin
                    next_ctrl = pwdata[CTRL_W-1:0];
                end
                REG_STATUS: begin
                    next_status = status & ~pwdata[EV_W-1:0];
                end
                REG_MASK: begin
                    next_mask = pwdata[EV_W-1:0];
                end
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end
        next_status = next_status | ev_set;
        if (xfer) begin
            next_beats = beats + 1'b1;
        end
        // Read data captured in the setup phase
        if (rd_setup) begin
            next_prdata = '0;
            case (paddr)
                REG_CTRL: begin
                    next_prdata[CTRL_W-1:0] = ctrl;
                end
                REG_STATUS: begin
                    next_prdata[EV_W-1:0] = status;
                end
                REG_MASK: begin
                    next_prdata[EV_W-1:0] = mask;
                end
                REG_BEATS: begin
                    next_prdata = beats;
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    // Register file flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= CTRL_RST;
            status <= EV_RST;
            mask   <= EV_RST;
            beats  <= '0;
            prdata <= '0;
        end else begin
            ctrl   <= next_ctrl;
            status <= next_status;
            mask   <= next_mask;
            beats  <= next_beats;
            prdata <= next_prdata;
        end
    end

    // Level interrupt while any unmasked event stays set
    assign irq = |(status & mask);

endmodule
`default_nettype wire

// ### test/ces_framer_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Sideband checker for the completion framer
// ============================================================
module ces_framer_properties
    import ces_pkg::*;
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // Beat source handshake
    input wire logic              src_valid,
    input wire logic              src_ready,
    // Completion stream
    input wire logic              completion_stream_valid,
    input wire logic              completion_stream_ready,
    input wire logic [DATA_W-1:0] completion_stream_data,
    input wire logic              completion_stream_last,
    input wire logic [SB_W-1:0]   completion_sideband,
    // Error report
    input wire logic              aer_report
);
    wire logic        v  = completion_stream_valid;   // Beat offered
    wire logic [3:0]  sf = completion_sideband[67:64]; // Start flags
    wire logic [7:0]  sl = completion_sideband[75:68]; // Start lane codes
    wire logic [3:0]  ef = completion_sideband[79:76]; // End flags
    wire logic [15:0] ep = completion_sideband[95:80]; // Last-Dword offsets
    wire logic        dc = completion_sideband[96];    // Discard flag
    logic [BYTE_N-1:0] par_exp;                        // Expected odd parity

    // Odd parity of every data byte
    always_comb begin
        for (int i = 0; i < BYTE_N; i++) begin
            par_exp[i] = ~^completion_stream_data[8*i +: 8];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_end_thermo: assert property (v |-> ef inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("end flags carry a reserved code");
    a_last_no_ends: assert property (v && completion_stream_last |-> ef == 4'h0 && ep == 16'h0)
        else $error("end fields set on an unstraddled last beat");
    a_offs_gated: assert property (v |-> (ep & {{4{ef[3]}}, {4{ef[2]}}, {4{ef[1]}}, {4{ef[0]}}}) == ep)
        else $error("offset set for a slot that does not end");
    a_start_thermo: assert property (v |-> sf inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("start flags carry a reserved code");
    a_lane_gated: assert property (v |-> (sl & {{2{sf[3]}}, {2{sf[2]}}, {2{sf[1]}}, {2{sf[0]}}}) == sl)
        else $error("lane code set for a slot that does not start");
    a_disc_end: assert property (v && dc |-> ef[0] || completion_stream_last)
        else $error("discard outside a final beat");
    a_disc_nostart: assert property (v && dc && ef[0] |-> sf == 4'h0)
        else $error("new packet started in a discard beat");
    a_parity_ok: assert property (v |-> completion_sideband[160:97] == par_exp)
        else $error("parity does not match data");
    a_beat_hold: assert property (v && !completion_stream_ready |=>
        v && $stable(completion_sideband) && $stable(completion_stream_data))
        else $error("beat changed before it was accepted");
    a_beat_answer: assert property (src_valid && src_ready |=> v)
        else $error("taken beat not offered next cycle");
    a_aer_cause: assert property (aer_report |-> $past(v && completion_stream_ready && dc))
        else $error("error report without a discarded beat");
endmodule

bind ces_framer ces_framer_properties u_props (
    .pclk(pclk), .presetn(presetn), .src_valid(src_valid), .src_ready(src_ready),
    .completion_stream_valid(completion_stream_valid),
    .completion_stream_ready(completion_stream_ready),
    .completion_stream_data(completion_stream_data),
    .completion_stream_last(completion_stream_last),
    .completion_sideband(completion_sideband), .aer_report(aer_report));
`default_nettype wire

// ### test/ces_client.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Client logic receiving completion packets
// ============================================================
module ces_client
    import ces_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Pacing: stall three cycles in four when set
    input  wire logic            slow,
    // Completion stream in
    input  wire logic            valid,
    output logic                 ready,
    input  wire logic            last,
    input  wire logic [SB_W-1:0] sb,
    input  wire logic [DATA_W-1:0] data,
    // Last accepted beat and counts
    output logic [SB_W-1:0]      seen_sb,
    output logic [DATA_W-1:0]    seen_data,
    output logic                 seen_last,
    output logic [15:0]          beats,
    output logic [15:0]          tlp_drop
);
    logic [1:0] pace; // Stall pattern phase

    // Accept beats and count those flagged for discard
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pace      <= 2'h0;
            ready     <= 1'b0;
            seen_sb   <= '0;
            seen_data <= '0;
            seen_last <= 1'b0;
            beats     <= 16'h0;
            tlp_drop  <= 16'h0;
        end else begin
            pace  <= pace + 2'h1;
            ready <= !slow || (pace == 2'h2);
            if (valid && ready) begin
                seen_sb   <= sb;
                seen_data <= data;
                seen_last <= last;
                beats     <= beats + 16'h1;
                if (sb[SB_DISC_BIT]) begin
                    tlp_drop <= tlp_drop + 16'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### test/ces_framer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Completion framer bench
// ============================================================
module ces_framer_tb_top
    import ces_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, aer_report, err, strad = 1'b0, slow = 1'b0;
    logic src_valid = 1'b0, src_ready, src_last = 1'b0;
    logic src_payload_error = 1'b0, src_has_payload = 1'b0;
    logic [DATA_W-1:0] src_data = '0, completion_stream_data, seen_data;
    logic [2:0] src_start_count = 3'h0, src_end_count = 3'h0;
    logic [7:0] src_start_lanes = 8'h0;
    logic [15:0] src_end_offsets = 16'h0, beats, tlp_drop;
    logic completion_stream_valid, completion_stream_ready, completion_stream_last, seen_last;
    logic [SB_W-1:0] completion_sideband, seen_sb;
    int miscompares = 0, checks_done = 0, nsent = 0, naer = 0;

    always #5 pclk = ~pclk;

    ces_framer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .src_valid, .src_ready, .src_data,
        .src_start_count, .src_start_lanes, .src_end_count, .src_end_offsets, .src_last,
        .src_payload_error, .src_has_payload, .completion_stream_valid,
        .completion_stream_ready, .completion_stream_data, .completion_stream_last,
        .completion_sideband, .aer_report);
    ces_client u_client (.clk(pclk), .rst_n(presetn), .slow, .valid(completion_stream_valid),
        .ready(completion_stream_ready), .last(completion_stream_last),
        .sb(completion_sideband), .data(completion_stream_data), .seen_sb, .seen_data,
        .seen_last, .beats, .tlp_drop);

    // Count error report pulses
    always @(posedge pclk) if (aer_report === 1'b1) naer++;

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [SB_W-1:0] seen, input logic [SB_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a level at the falling edge
    task automatic await(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1) begin
            @(negedge pclk);
            n++;
            if (n > 60) begin
                miscompares++;
                stop_test();
            end
        end
    endtask

    // One APB transfer; data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 60);
        if (pready !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(err, 1'b0);
    endtask

    // Expected sideband for the beat now on the source
    function automatic logic [SB_W-1:0] exp_sb();
        logic [SB_W-1:0] e;
        logic [3:0] sf;
        logic [3:0] ef;
        sf = strad ? 4'((5'h1 << src_start_count) - 5'h1) : {3'h0, src_start_count != 3'h0};
        ef = strad ? 4'((5'h1 << src_end_count) - 5'h1) : 4'h0;
        e = '0;
        e[96] = src_payload_error && src_has_payload && (strad ? ef[0] : src_last);
        if (e[96] && strad) sf = 4'h0;
        e[67:64] = sf;
        e[79:76] = ef;
        for (int k = 0; k < 4; k++) begin
            e[68+2*k +: 2] = (strad && sf[k]) ? src_start_lanes[2*k +: 2] : 2'h0;
            e[80+4*k +: 4] = ef[k] ? src_end_offsets[4*k +: 4] : 4'h0;
        end
        for (int i = 0; i < BYTE_N; i++) e[97+i] = ~^src_data[8*i +: 8];
        return e;
    endfunction

    // Offer one beat, then compare what the client accepted
    task automatic send(input logic [2:0] sc, input logic [2:0] ec, input logic lst,
                        input logic pe, input logic hp);
        logic [15:0] b0;
        int n;
        b0 = beats;
        @(posedge pclk);
        src_data <= {16{32'h5a3c0f01 ^ 32'(nsent * 7)}};
        src_start_count <= sc;
        src_start_lanes <= 8'he4;
        src_end_count <= ec;
        src_end_offsets <= 16'h4a5b;
        src_last <= lst;
        src_payload_error <= pe;
        src_has_payload <= hp;
        src_valid <= 1'b1;
        @(negedge pclk);
        await(src_ready);
        @(posedge pclk);
        src_valid <= 1'b0;
        nsent++;
        n = 0;
        while (beats == b0) begin
            @(negedge pclk);
            n++;
            if (n > 60) begin
                miscompares++;
                stop_test();
            end
        end
        chk(seen_sb, exp_sb());
        chk(seen_last, !strad && lst);
        chk(seen_data[SB_W-1:0], src_data[SB_W-1:0]);
        chk(seen_data[DATA_W-1 -: SB_W], src_data[DATA_W-1 -: SB_W]);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_MASK, 32'h0);
        rdchk(REG_STATUS, 32'h0);
        // Unmapped place answers with an error and zero data
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        // Unstraddled: offsets held zero, last marks the end
        send(3'h1, 3'h2, 1'b1, 1'b0, 1'b1);
        send(3'h1, 3'h0, 1'b0, 1'b1, 1'b1);
        send(3'h0, 3'h1, 1'b1, 1'b1, 1'b1);
        rdchk(REG_STATUS, 32'h1);
        chk(irq, 1'b0);
        apb(1'b1, REG_MASK, 32'h3);
        rdchk(REG_MASK, 32'h3);
        @(negedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, REG_STATUS, 32'h1);
        @(negedge pclk);
        chk(irq, 1'b0);
        // Straddled, endpoint, client stalling
        apb(1'b1, REG_CTRL, 32'h3);
        rdchk(REG_CTRL, 32'h3);
        strad = 1'b1;
        slow <= 1'b1;
        for (int k = 0; k <= 4; k++) send(3'(k), 3'(4 - k), 1'b1, 1'b0, 1'b1);
        send(3'h2, 3'h0, 1'b1, 1'b1, 1'b1);
        send(3'h2, 3'h3, 1'b1, 1'b1, 1'b0);
        send(3'h2, 3'h1, 1'b0, 1'b1, 1'b1);
        rdchk(REG_STATUS, 32'h3);
        chk(irq, 1'b1);
        apb(1'b1, REG_MASK, 32'h0);
        @(negedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, REG_STATUS, 32'h3);
        rdchk(REG_STATUS, 32'h0);
        apb(1'b1, REG_BEATS, 32'hffff);
        rdchk(REG_BEATS, 32'(nsent));
        chk(naer, 1);
        chk(tlp_drop, 16'h2);
        stop_test();
    end
endmodule
`default_nettype wire
